// [rtl/epd_pkg.sv]
package epd_pkg;
  // Register indices on the 7-bit register port
  localparam logic [6:0] EPD_POLE = 7'h1B;
  localparam logic [6:0] EPD_P_CTRL = 7'h25;
  localparam logic [6:0] EPD_P_PPR = 7'h26;
  localparam logic [6:0] EPD_P_COUNT = 7'h27;
  localparam logic [6:0] EPD_P_IDX = 7'h28;
  localparam logic [6:0] EPD_P_OFFS = 7'h29;
  localparam logic [6:0] EPD_P_ANGLES = 7'h2A;
  localparam logic [6:0] EPD_S_CTRL = 7'h2C;
  localparam logic [6:0] EPD_S_PPR = 7'h2D;
  localparam logic [6:0] EPD_S_COUNT = 7'h2E;
  localparam logic [6:0] EPD_S_IDX = 7'h2F;
  localparam logic [6:0] EPD_S_OFFS = 7'h30;
  localparam logic [6:0] EPD_S_MECH = 7'h31;
  localparam logic [6:0] EPD_H_CTRL = 7'h33;
  localparam logic [6:0] EPD_H_POS_A = 7'h34;
  localparam logic [6:0] EPD_H_POS_B = 7'h35;
  localparam logic [6:0] EPD_H_POS_C = 7'h36;
  localparam logic [6:0] EPD_H_OFFS = 7'h37;
  localparam logic [6:0] EPD_H_STEP = 7'h38;
  localparam logic [6:0] EPD_H_ELEC = 7'h39;
  localparam logic [6:0] EPD_H_MECH = 7'h3A;
  localparam logic [6:0] EPD_A_CTRL = 7'h3B;
  localparam logic [6:0] EPD_A_THR = 7'h3C;
  localparam logic [6:0] EPD_A_RAW = 7'h3D;
  localparam logic [6:0] EPD_A_OFFS = 7'h3E;
  localparam logic [6:0] EPD_A_RES = 7'h3F;
  localparam logic [6:0] EPD_A_PPR = 7'h40;
  localparam logic [6:0] EPD_A_COUNT = 7'h41;
  // Control bit positions
  localparam int EPD_POL_A = 0;
  localparam int EPD_POL_B = 1;
  localparam int EPD_POL_N = 2;
  localparam int EPD_QUAL = 3;
  localparam int EPD_CLR = 8;
  localparam int EPD_DIR = 12;
  localparam int EPD_HALL_POL = 0;
  localparam int EPD_HALL_INTERP = 8;
  localparam int EPD_HALL_DIR = 12;
  localparam int EPD_AENC_3PH = 0;
  localparam int EPD_AENC_DIR = 12;
  // Writable bit masks of the control registers
  localparam logic [31:0] EPD_CTRL_MASK = 32'h0000_110F;
  localparam logic [31:0] EPD_HALL_MASK = 32'h0000_1101;
  localparam logic [31:0] EPD_AENC_MASK = 32'h0000_1001;
  // Reset values other than zero
  localparam logic [15:0] EPD_POLE_RST = 16'h0001;
  localparam logic [15:0] EPD_APPR_RST = 16'h0001;
  // Angle constants, one turn is 2^16
  localparam logic [15:0] EPD_SECTOR_SPAN = 16'h2AAB;
  localparam logic [15:0] EPD_HALF_TURN = 16'h8000;
  localparam logic [17:0] EPD_INV_SQRT3 = 18'h0_93CD;
  // Interpolation tick timing
  localparam int EPD_CLK_MHZ = 250;
  localparam int EPD_TICK_NS = 1000;
  localparam int EPD_TICK_CYC = EPD_TICK_NS * EPD_CLK_MHZ / 1000;
  // Angle solver steps and arctangent table, entry 0 in the low bits
  localparam int EPD_CORDIC_N = 12;
  localparam logic [11:0][15:0] EPD_ATAN = {
    16'h0005, 16'h000A, 16'h0014, 16'h0029, 16'h0051, 16'h00A3,
    16'h0146, 16'h028B, 16'h0511, 16'h09FB, 16'h12E4, 16'h2000};
endpackage

// [rtl/epd_incr.sv]
`timescale 1ns/1ns
`default_nettype none
module epd_incr import epd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Encoder inputs
  input wire logic in_a,
  input wire logic in_b,
  input wire logic in_n,
  // Settings
  input wire logic [31:0] ctrl,
  input wire logic [23:0] ppr,
  input wire logic [15:0] mech_offset,
  // Software writes
  input wire logic cnt_wr,
  input wire logic idx_wr,
  input wire logic [23:0] wdata,
  // Results
  output logic [23:0] count,
  output logic [23:0] index_count,
  output logic [15:0] mech_angle
);
  // Divider states
  typedef enum logic [0:0] {EPD_DIV_IDLE = 1'b0, EPD_DIV_RUN = 1'b1} epd_div_e;
  // Whole decoder state
  typedef struct packed {
    logic a_q;
    logic b_q;
    logic n_q;
    logic [23:0] cnt;
    logic [23:0] idx;
    epd_div_e div;
    logic [3:0] bit_i;
    logic [24:0] rem;
    logic [15:0] quo;
    logic [15:0] mech;
  } epd_incr_s;
  epd_incr_s st, next_st;
  logic a, b, nq, step, up, evt;
  logic [24:0] shl;

  // Input conditioning and next state
  always_comb begin
    next_st = st;
    a = in_a ^ ctrl[EPD_POL_A];
    b = in_b ^ ctrl[EPD_POL_B];
    nq = (in_n ^ ctrl[EPD_POL_N]) & (~ctrl[EPD_QUAL] | (a & b));
    step = (a ^ st.a_q) ^ (b ^ st.b_q);
    up = (a ^ st.b_q) ^ ctrl[EPD_DIR];
    evt = nq & ~st.n_q;
    shl = {st.rem[23:0], 1'b0};
    next_st.a_q = a;
    next_st.b_q = b;
    next_st.n_q = nq;
    // Count modulo pulses per turn
    if (step) begin
      if (up) begin
        next_st.cnt = (ppr != 24'h00_0000 && st.cnt >= ppr - 24'h00_0001) ?
          24'h00_0000 : st.cnt + 24'h00_0001;
      end else begin
        next_st.cnt = (st.cnt != 24'h00_0000) ? st.cnt - 24'h00_0001 :
          ppr - 24'h00_0001;
      end
    end
    // Index capture and optional load
    if (evt) begin
      if (ctrl[EPD_CLR]) begin
        next_st.cnt = st.idx;
        next_st.idx = 24'h00_0000;
      end else begin
        next_st.idx = st.cnt;
      end
    end
    // Software writes take precedence
    if (cnt_wr) begin
      next_st.cnt = wdata;
    end
    if (idx_wr) begin
      next_st.idx = wdata;
    end
    // Restoring divider, count * 2^16 / ppr
    case (st.div)
      EPD_DIV_IDLE: begin
        next_st.rem = {1'b0, st.cnt};
        next_st.quo = 16'h0000;
        next_st.bit_i = 4'h0;
        next_st.div = EPD_DIV_RUN;
      end
      EPD_DIV_RUN: begin
        if (shl >= {1'b0, ppr}) begin
          next_st.rem = shl - {1'b0, ppr};
          next_st.quo = {st.quo[14:0], 1'b1};
        end else begin
          next_st.rem = shl;
          next_st.quo = {st.quo[14:0], 1'b0};
        end
        next_st.bit_i = st.bit_i + 4'h1;
        if (st.bit_i == 4'hF) begin
          next_st.mech = ((ppr == 24'h00_0000) ? 16'h0000 : next_st.quo) + mech_offset;
          next_st.div = EPD_DIV_IDLE;
        end
      end
      default: next_st.div = EPD_DIV_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.cnt;
  assign index_count = st.idx;
  assign mech_angle = st.mech;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_index_latch: assert property (evt && !ctrl[EPD_CLR] && !idx_wr |=> st.idx == $past(st.cnt))
    else $error("index latch missed count");
  a_clear_load: assert property (evt && ctrl[EPD_CLR] && !cnt_wr && !idx_wr
    |=> st.cnt == $past(st.idx) && st.idx == 24'h00_0000)
    else $error("clear on index did not load");
  a_count_wrap: assert property (step && up && !evt && !cnt_wr && ppr != 24'h00_0000
    && st.cnt == ppr - 24'h00_0001 |=> st.cnt == 24'h00_0000)
    else $error("count did not wrap");
  a_dir_sense: assert property (step && !up && !evt && !cnt_wr && st.cnt != 24'h00_0000
    |=> st.cnt == $past(st.cnt) - 24'h00_0001)
    else $error("count did not go down");
endmodule
`default_nettype wire

// [rtl/epd_top.sv]
// Operation
// - Primary clear-on-index loads stored index count
// - Direction bit zero counts up, one reverses
// - Primary 24-bit count wraps modulo pulses-per-turn
// - Index latches count, zero when clearing
// - Primary mechanical angle scaled plus offset
// - Electrical angle is mechanical times pole pairs
// - Index qualify optionally needs A and B
// - Polarity bits invert A, B, index
// - Secondary count modulo own pulses-per-turn
// - Secondary clear-on-index loads its index count
// - Secondary index latch, zero when clearing
// - Secondary gives mechanical angle only
// - Hall raw and interpolated angles, interpolation bit
// - Six programmable hall sector angles
// - Hall mechanical and electrical offsets
// - Interpolator advance limited to max step
// - Analog mode bit selects sin/cos or three-phase
// - Analog mode bit twelve sets count direction
// - Analog index from threshold compare
// - Analog raw angle computed, read-only
// - Analog result is raw plus offset
// - Analog periods per turn, reset one
// - Pole pairs 16-bit, reset one
`timescale 1ns/1ns
`default_nettype none
module epd_top import epd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Primary incremental encoder
  input wire logic enc1_a,
  input wire logic enc1_b,
  input wire logic enc1_n,
  // Secondary incremental encoder
  input wire logic enc2_a,
  input wire logic enc2_b,
  input wire logic enc2_n,
  // Digital hall sensors
  input wire logic [2:0] hall_in,
  // Analog encoder samples
  input wire logic [15:0] aenc_ux,
  input wire logic [15:0] aenc_vn,
  input wire logic [15:0] aenc_wy,
  input wire logic [15:0] aenc_n,
  // Digital index from the analog index
  output logic aenc_index
);
  // Angle solver states
  typedef enum logic [1:0] {
    EPD_C_IDLE = 2'b00,
    EPD_C_RUN = 2'b01,
    EPD_C_DONE = 2'b10
  } epd_cordic_e;
  // Whole block state
  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] p_ctrl;
    logic [23:0] p_ppr;
    logic [31:0] p_offs;
    logic [15:0] pole;
    logic [15:0] p_elec;
    logic [31:0] s_ctrl;
    logic [23:0] s_ppr;
    logic [15:0] s_offs;
    logic [31:0] h_ctrl;
    logic [5:0][15:0] h_pos;
    logic [31:0] h_offs;
    logic [15:0] h_step;
    logic [2:0] h_sec;
    logic h_fwd;
    logic [15:0] h_raw;
    logic [15:0] h_interp;
    logic [7:0] tick;
    logic [31:0] a_ctrl;
    logic [15:0] a_thr;
    logic [15:0] a_offs;
    logic [15:0] a_ppr;
    logic [31:0] a_count;
    logic [15:0] a_raw;
    logic [15:0] a_res;
    logic a_idx;
    epd_cordic_e c_st;
    logic [3:0] c_i;
    logic signed [19:0] cx;
    logic signed [19:0] cy;
    logic [15:0] cz;
  } epd_top_s;
  epd_top_s st, next_st;

  // Decoder results
  logic [23:0] p_count, p_idx, s_count, s_idx;
  logic [15:0] p_mech, s_mech;
  // Write strobes into the decoders
  logic p_cnt_wr, p_idx_wr, s_cnt_wr, s_idx_wr;
  // Hall and solver helpers
  logic [2:0] hall_pol, sec;
  logic [15:0] h_lim, h_left, h_inc;
  logic signed [16:0] vw;
  logic signed [35:0] beta_p;
  logic signed [19:0] ld_x, ld_y, sx, sy;
  logic [31:0] pole_prod;

  // Hall state to sector index, seven when invalid
  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'b001: hall_sector = 3'd0;
      3'b011: hall_sector = 3'd1;
      3'b010: hall_sector = 3'd2;
      3'b110: hall_sector = 3'd3;
      3'b100: hall_sector = 3'd4;
      3'b101: hall_sector = 3'd5;
      default: hall_sector = 3'd7;
    endcase
  endfunction

  assign p_cnt_wr = reg_wr && reg_addr == EPD_P_COUNT;
  assign p_idx_wr = reg_wr && reg_addr == EPD_P_IDX;
  assign s_cnt_wr = reg_wr && reg_addr == EPD_S_COUNT;
  assign s_idx_wr = reg_wr && reg_addr == EPD_S_IDX;

  // Primary decoder, feeds commutation
  epd_incr u_primary (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_a(enc1_a),
    .in_b(enc1_b),
    .in_n(enc1_n),
    .ctrl(st.p_ctrl),
    .ppr(st.p_ppr),
    .mech_offset(st.p_offs[15:0]),
    .cnt_wr(p_cnt_wr),
    .idx_wr(p_idx_wr),
    .wdata(reg_wdata[23:0]),
    .count(p_count),
    .index_count(p_idx),
    .mech_angle(p_mech)
  );

  // Secondary decoder, position or velocity feedback only
  epd_incr u_secondary (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_a(enc2_a),
    .in_b(enc2_b),
    .in_n(enc2_n),
    .ctrl(st.s_ctrl),
    .ppr(st.s_ppr),
    .mech_offset(st.s_offs),
    .cnt_wr(s_cnt_wr),
    .idx_wr(s_idx_wr),
    .wdata(reg_wdata[23:0]),
    .count(s_count),
    .index_count(s_idx),
    .mech_angle(s_mech)
  );

  // Next state of registers, hall, analog solver
  always_comb begin
    next_st = st;
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        EPD_POLE: next_st.pole = reg_wdata[15:0];
        EPD_P_CTRL: next_st.p_ctrl = reg_wdata & EPD_CTRL_MASK;
        EPD_P_PPR: next_st.p_ppr = reg_wdata[23:0];
        EPD_P_OFFS: next_st.p_offs = reg_wdata;
        EPD_S_CTRL: next_st.s_ctrl = reg_wdata & EPD_CTRL_MASK;
        EPD_S_PPR: next_st.s_ppr = reg_wdata[23:0];
        EPD_S_OFFS: next_st.s_offs = reg_wdata[15:0];
        EPD_H_CTRL: next_st.h_ctrl = reg_wdata & EPD_HALL_MASK;
        EPD_H_POS_A: next_st.h_pos[1:0] = reg_wdata;
        EPD_H_POS_B: next_st.h_pos[3:2] = reg_wdata;
        EPD_H_POS_C: next_st.h_pos[5:4] = reg_wdata;
        EPD_H_OFFS: next_st.h_offs = reg_wdata;
        EPD_H_STEP: next_st.h_step = reg_wdata[15:0];
        EPD_A_CTRL: next_st.a_ctrl = reg_wdata & EPD_AENC_MASK;
        EPD_A_THR: next_st.a_thr = reg_wdata[15:0];
        EPD_A_OFFS: next_st.a_offs = reg_wdata[15:0];
        EPD_A_PPR: next_st.a_ppr = reg_wdata[15:0];
        default: next_st.rvalid = st.rvalid;
      endcase
    end
    // Primary electrical angle
    pole_prod = {16'h0000, p_mech} * {16'h0000, st.pole};
    next_st.p_elec = pole_prod[15:0] + st.p_offs[31:16];
    // Hall sector after polarity and direction
    hall_pol = hall_in ^ {3{st.h_ctrl[EPD_HALL_POL]}};
    sec = hall_sector(hall_pol);
    if (st.h_ctrl[EPD_HALL_DIR] && sec != 3'd7 && sec != 3'd0) begin
      sec = 3'd6 - sec;
    end
    // Interpolation step toward the sector edge
    h_lim = st.h_fwd ? st.h_raw + EPD_SECTOR_SPAN : st.h_raw - EPD_SECTOR_SPAN;
    h_left = st.h_fwd ? h_lim - st.h_interp : st.h_interp - h_lim;
    h_inc = (h_left > st.h_step) ? st.h_step : h_left;
    next_st.tick = (st.tick == 8'(EPD_TICK_CYC - 1)) ? 8'h00 : st.tick + 8'h01;
    if (sec != 3'd7) begin
      next_st.h_raw = st.h_pos[sec];
      next_st.h_sec = sec;
    end
    if (sec != 3'd7 && sec != st.h_sec) begin
      next_st.h_fwd = (sec == ((st.h_sec == 3'd5) ? 3'd0 : st.h_sec + 3'd1));
      next_st.h_interp = st.h_pos[sec];
    end else if (!st.h_ctrl[EPD_HALL_INTERP]) begin
      next_st.h_interp = st.h_raw;
    end else if (st.tick == 8'h00) begin
      next_st.h_interp = st.h_fwd ? st.h_interp + h_inc : st.h_interp - h_inc;
    end
    // Analog index by threshold
    next_st.a_idx = $signed(aenc_n) > $signed(st.a_thr);
    // Solver input vector
    vw = $signed({aenc_vn[15], aenc_vn}) - $signed({aenc_wy[15], aenc_wy});
    beta_p = vw * $signed({1'b0, EPD_INV_SQRT3});
    ld_x = 20'(signed'(aenc_ux));
    if (st.a_ctrl[EPD_AENC_3PH]) begin
      ld_y = 20'(signed'(beta_p[32:16]));
    end else begin
      ld_y = 20'(signed'(aenc_vn));
    end
    sx = st.cx >>> st.c_i;
    sy = st.cy >>> st.c_i;
    // Vectoring solver for the raw analog angle
    case (st.c_st)
      EPD_C_IDLE: begin
        next_st.cx = ld_x[19] ? -ld_x : ld_x;
        next_st.cy = ld_x[19] ? -ld_y : ld_y;
        next_st.cz = ld_x[19] ? EPD_HALF_TURN : 16'h0000;
        next_st.c_i = 4'h0;
        next_st.c_st = EPD_C_RUN;
      end
      EPD_C_RUN: begin
        if (!st.cy[19]) begin
          next_st.cx = st.cx + sy;
          next_st.cy = st.cy - sx;
          next_st.cz = st.cz + EPD_ATAN[st.c_i];
        end else begin
          next_st.cx = st.cx - sy;
          next_st.cy = st.cy + sx;
          next_st.cz = st.cz - EPD_ATAN[st.c_i];
        end
        next_st.c_i = st.c_i + 4'h1;
        if (st.c_i == 4'(EPD_CORDIC_N - 1)) begin
          next_st.c_st = EPD_C_DONE;
        end
      end
      EPD_C_DONE: begin
        next_st.a_raw = st.cz;
        next_st.a_res = st.cz + st.a_offs;
        // Period wrap counts one step, sense from mode bit twelve
        if (st.a_raw[15:14] == 2'b11 && st.cz[15:14] == 2'b00) begin
          next_st.a_count = st.a_ctrl[EPD_AENC_DIR] ? st.a_count - 32'h0000_0001 :
            st.a_count + 32'h0000_0001;
        end else if (st.a_raw[15:14] == 2'b00 && st.cz[15:14] == 2'b11) begin
          next_st.a_count = st.a_ctrl[EPD_AENC_DIR] ? st.a_count + 32'h0000_0001 :
            st.a_count - 32'h0000_0001;
        end
        next_st.c_st = EPD_C_IDLE;
      end
      default: next_st.c_st = EPD_C_IDLE;
    endcase
    if (reg_wr && reg_addr == EPD_A_COUNT) begin
      next_st.a_count = reg_wdata;
    end
    // Read answer, one cycle after the strobe
    next_st.rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        EPD_POLE: next_st.rdata = {16'h0000, st.pole};
        EPD_P_CTRL: next_st.rdata = st.p_ctrl;
        EPD_P_PPR: next_st.rdata = {8'h00, st.p_ppr};
        EPD_P_COUNT: next_st.rdata = {8'h00, p_count};
        EPD_P_IDX: next_st.rdata = {8'h00, p_idx};
        EPD_P_OFFS: next_st.rdata = st.p_offs;
        EPD_P_ANGLES: next_st.rdata = {st.p_elec, p_mech};
        EPD_S_CTRL: next_st.rdata = st.s_ctrl;
        EPD_S_PPR: next_st.rdata = {8'h00, st.s_ppr};
        EPD_S_COUNT: next_st.rdata = {8'h00, s_count};
        EPD_S_IDX: next_st.rdata = {8'h00, s_idx};
        EPD_S_OFFS: next_st.rdata = {16'h0000, st.s_offs};
        EPD_S_MECH: next_st.rdata = {16'h0000, s_mech};
        EPD_H_CTRL: next_st.rdata = st.h_ctrl;
        EPD_H_POS_A: next_st.rdata = st.h_pos[1:0];
        EPD_H_POS_B: next_st.rdata = st.h_pos[3:2];
        EPD_H_POS_C: next_st.rdata = st.h_pos[5:4];
        EPD_H_OFFS: next_st.rdata = st.h_offs;
        EPD_H_STEP: next_st.rdata = {16'h0000, st.h_step};
        EPD_H_ELEC: next_st.rdata = {st.h_interp + st.h_offs[31:16],
          st.h_raw + st.h_offs[31:16]};
        EPD_H_MECH: next_st.rdata = {16'h0000, st.h_raw + st.h_offs[15:0]};
        EPD_A_CTRL: next_st.rdata = st.a_ctrl;
        EPD_A_THR: next_st.rdata = {16'h0000, st.a_thr};
        EPD_A_RAW: next_st.rdata = {16'h0000, st.a_raw};
        EPD_A_OFFS: next_st.rdata = {16'h0000, st.a_offs};
        EPD_A_RES: next_st.rdata = {16'h0000, st.a_res};
        EPD_A_PPR: next_st.rdata = {16'h0000, st.a_ppr};
        EPD_A_COUNT: next_st.rdata = st.a_count;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with the nonzero resets
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.pole <= EPD_POLE_RST;
      st.a_ppr <= EPD_APPR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign aenc_index = st.a_idx;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_solve_start;
    st.c_st == EPD_C_IDLE ##1 st.c_st == EPD_C_RUN;
  endsequence
  a_solver_span: assert property (s_solve_start |-> ##12 st.c_st == EPD_C_DONE)
    else $error("angle solver took wrong cycles");
  a_result_offset: assert property (st.c_st == EPD_C_DONE && !reg_wr
    |=> st.a_res == st.a_raw + st.a_offs)
    else $error("analog result offset wrong");
  a_elec_read: assert property (reg_rd && reg_addr == EPD_P_ANGLES
    |=> reg_rvalid && reg_rdata[31:16] == $past(st.p_elec))
    else $error("electrical angle readback wrong");
  a_hall_select: assert property (hall_sector(hall_pol) != 3'd7 && !st.h_ctrl[EPD_HALL_DIR]
    && !reg_wr |=> st.h_raw == $past(st.h_pos[hall_sector(hall_pol)]))
    else $error("hall sector angle wrong");
  a_interp_off: assert property (!st.h_ctrl[EPD_HALL_INTERP] && $stable(st.h_sec)
    && reg_rd && reg_addr == EPD_H_ELEC |=> reg_rdata[31:16] == reg_rdata[15:0])
    else $error("interpolated angle differs while off");
  a_interp_limit: assert property (st.tick == 8'h00 && st.h_ctrl[EPD_HALL_INTERP]
    && sec == st.h_sec |=> (st.h_interp - $past(st.h_interp) <= $past(st.h_step))
    || ($past(st.h_interp) - st.h_interp <= $past(st.h_step)))
    else $error("interpolator step too large");
  a_index_thresh: assert property ($signed(aenc_n) > $signed(st.a_thr) && !reg_wr
    |=> aenc_index)
    else $error("analog index missing");
  a_aenc_dir: assert property (st.c_st == EPD_C_DONE && !st.a_ctrl[EPD_AENC_DIR]
    && st.a_raw[15:14] == 2'b11 && st.cz[15:14] == 2'b00 && !reg_wr
    |=> st.a_count == $past(st.a_count) + 32'h0000_0001)
    else $error("analog count sense wrong");
endmodule
`default_nettype wire

// [verification/epd_enc_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Quadrature and index source standing in for an incremental encoder
module epd_enc_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Motion commands
  input wire logic step,
  input wire logic back,
  input wire logic idx,
  // Encoder lines
  output logic a,
  output logic b,
  output logic n
);
  logic [1:0] phase; // Position within one quadrature cycle
  // One phase step per cycle; A leads B going forward
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
      n <= 1'b0;
    end else begin
      if (step) phase <= back ? phase - 2'h1 : phase + 2'h1;
      n <= idx;
    end
  end
  // Gray coding, only one line changes per step
  assign a = phase[0] ^ phase[1];
  assign b = phase[1];
endmodule
`default_nettype wire

// [verification/tb_encoder_position_decoders.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_encoder_position_decoders import epd_pkg::*;;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, aenc_index, a1, b1, n1, a2, b2, n2;
  logic step = 1'b0, back = 1'b0, idx = 1'b0;
  logic [2:0] hall_in = 3'h0;
  logic [15:0] ux = 16'h0000, vn = 16'h0000, wy = 16'h0000, an = 16'h0000, thr, mo, eo;
  logic [15:0] pos [6];
  logic [2:0] hs [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int errors = 0, samples_checked = 0, cyc = 0;
  // Device under test
  epd_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .enc1_a(a1), .enc1_b(b1), .enc1_n(n1), .enc2_a(a2),
    .enc2_b(b2), .enc2_n(n2), .hall_in(hall_in), .aenc_ux(ux), .aenc_vn(vn),
    .aenc_wy(wy), .aenc_n(an), .aenc_index(aenc_index));
  // Primary encoder
  epd_enc_model i_enc (.clk_sys(clk_sys), .arst_n(arst_n), .step(step), .back(back),
    .idx(idx), .a(a1), .b(b1), .n(n1));
  // Secondary encoder, same motion as the primary
  epd_enc_model i_enc2 (.clk_sys(clk_sys), .arst_n(arst_n), .step(step), .back(back),
    .idx(idx), .a(a2), .b(b2), .n(n2));
  // Clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end
  // Expected mechanical angle
  function automatic logic [15:0] mech_exp(logic [23:0] c, logic [23:0] p, logic [15:0] o);
    return 16'((40'(c) << 16) / 40'(p)) + o;
  endfunction
  // Expected electrical angle
  function automatic logic [15:0] elec_exp(logic [15:0] m, logic [15:0] pp, logic [15:0] o);
    return 16'(m * pp) + o;
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register write, strobe one cycle
  task automatic wr(input logic [6:0] ad, input logic [31:0] dt);
    reg_addr = ad;
    reg_wdata = dt;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  // Register read, answer one cycle later
  task automatic rc(input logic [6:0] ad, input logic [31:0] e, input string nm);
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    // Answer stands for this one cycle only
    chk({31'h0, reg_rvalid}, 32'h1, "rvalid");
    chk(reg_rdata, e, nm);
    @(negedge clk_sys);
  endtask
  // Encoder motion
  task automatic stp(input int k, input logic bk);
    back = bk;
    step = 1'b1;
    repeat (k) @(negedge clk_sys);
    step = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Index pulse
  task automatic pulse();
    idx = 1'b1;
    repeat (3) @(negedge clk_sys);
    idx = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h3eb2));
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    rc(EPD_POLE, 32'h0000_0001, "pole");
    rc(EPD_A_PPR, 32'h0000_0001, "aperiods");
    rc(7'h7F, 32'h0000_0000, "unmapped");
    wr(EPD_P_PPR, 32'h0000_0004);
    wr(EPD_S_PPR, 32'h0000_0003);
    stp(5, 1'b0);
    rc(EPD_P_COUNT, 32'h0000_0001, "wrap");
    wr(EPD_P_CTRL, 32'h0000_1000);
    stp(2, 1'b0);
    rc(EPD_P_COUNT, 32'h0000_0003, "reverse");
    pulse();
    rc(EPD_P_IDX, 32'h0000_0003, "latch");
    rc(EPD_S_COUNT, 32'h0000_0001, "s_wrap");
    rc(EPD_S_IDX, 32'h0000_0001, "s_latch");
    wr(EPD_P_IDX, 32'h0000_0002);
    wr(EPD_S_IDX, 32'h0000_0002);
    wr(EPD_S_CTRL, 32'h0000_0100);
    wr(EPD_P_CTRL, 32'h0000_1100);
    pulse();
    rc(EPD_P_COUNT, 32'h0000_0002, "clrload");
    rc(EPD_P_IDX, 32'h0000_0000, "clrlatch");
    rc(EPD_S_COUNT, 32'h0000_0002, "s_clrload");
    rc(EPD_S_IDX, 32'h0000_0000, "s_clrlatch");
    mo = 16'($urandom);
    eo = 16'($urandom);
    wr(EPD_POLE, 32'h0000_0003);
    wr(EPD_P_OFFS, {eo, mo});
    repeat (40) @(negedge clk_sys);
    rc(EPD_P_ANGLES, {elec_exp(mech_exp(2, 4, mo), 3, eo), mech_exp(2, 4, mo)}, "ang");
    rc(EPD_S_MECH, {16'h0000, mech_exp(24'd2, 24'd3, 16'h0000)}, "s_mech");
    foreach (pos[k]) pos[k] = 16'($urandom);
    wr(EPD_H_POS_A, {pos[1], pos[0]});
    wr(EPD_H_POS_B, {pos[3], pos[2]});
    wr(EPD_H_POS_C, {pos[5], pos[4]});
    for (int p = 0; p < 2; p++) begin
      wr(EPD_H_CTRL, 32'(p));
      for (int k = 0; k < 6; k++) begin
        hall_in = p ? ~hs[k] : hs[k];
        repeat (3) @(negedge clk_sys);
        rc(EPD_H_ELEC, {2{pos[k]}}, "hall");
      end
    end
    // Interpolator runs a full sector span forward at the first tick
    wr(EPD_H_CTRL, 32'h0000_0101);
    wr(EPD_H_STEP, 32'h0000_FFFF);
    repeat (260) @(negedge clk_sys);
    rc(EPD_H_ELEC, {16'(pos[5] + EPD_SECTOR_SPAN), pos[5]}, "interp");
    thr = 16'($urandom);
    wr(EPD_A_THR, {16'h0, thr});
    for (int k = 0; k < 8; k++) begin
      an = (k == 0) ? thr : 16'($urandom);
      ux = 16'($urandom);
      vn = 16'($urandom);
      repeat (3) @(negedge clk_sys);
      chk({31'h0, aenc_index}, {31'h0, $signed(an) > $signed(thr)}, "aidx");
    end
    final_report();
  end
endmodule
`default_nettype wire
